// ---- core/febc_core.sv ----
// error status and boot configuration block, top level
// assumes the command engine reports outcomes on sys_clk; boot memory
// answers one cycle after a fetch pulse
`timescale 1ns/1ps
// Operation
// - extended status bit 0 always mirrors the main busy flag
// - protection error flag set when erase or program hits protected region
// - program error flag set on program or register write failure or protection
// - erase error flag set on erase or nv register failure or protection
// - program to protected or suspended target sets program and protection errors
// - info row program to locked region sets program and protection errors
// - mode lock reprogram or both lock bits zero sets program and protection
// - wrong unlock password sets program and protection errors
// - nv register update failure sets matching erase or program error
// - erase commands set erase error, plus protection error on protected target
// - chip erase meeting protected sectors sets neither erase nor protection error
// - clearing otp bits back to zero is ignored with no error
// - read only bits ignore written data and raise no error
// - error flags stay set until clear command, hardware or software reset
// - set error flags never block later commands
// - drive strength code in bits 7 to 5, default 111 for 50 percent
// - boot register 32 bits non-volatile, bit 0 enables boot, default off
// - bits 23 to 5 hold 512-byte aligned boot start address, default zero
// - bits 4 to 1 hold boot delay cycles after chip enable falls
// - bits 31 to 24 reserved and read as zero
// - set-params 85h writes nv and volatile copy, 83h volatile, status untouched
module febc_core
    import febc_pkg::*;
(
    input  wire logic                       sys_clk,
    input  wire logic                       rst,
    input  wire logic                       sck,
    input  wire logic                       ce_n,
    input  wire logic                       si,
    output logic                            so_r,
    output logic                            so_oe_r,
    input  wire logic                       busy,
    input  wire logic                       soft_rst,
    input  wire logic                       op_done,
    input  wire febc_pkg::febc_op_t         op_kind,
    input  wire logic                       op_fail,
    input  wire logic                       op_hit_protect,
    input  wire logic                       mode_chosen,
    input  wire logic [1:0]                 mode_lock_bits,
    input  wire logic                       pwd_match,
    input  wire logic                       nv_erase_fail,
    input  wire logic                       nv_prog_fail,
    input  wire logic [7:0]                 boot_data,
    output logic                            boot_fetch_r,
    output logic [febc_pkg::BOOT_ADDR_W-1:0] boot_addr_r,
    output logic [2:0]                      drive_sel_r,
    output logic                            boot_enable_r,
    output logic                            prot_err_r,
    output logic                            prog_err_r,
    output logic                            erase_err_r
);
    import febc_pkg::*;

    typedef enum logic [2:0] {
        ST_CMD, ST_RD_EXT, ST_RD_BOOT, ST_WR_EXT, ST_WR_BOOT, ST_IGNORE, ST_BOOT_WAIT,
        ST_BOOT_RUN
    } febc_state_t;

    febc_link_if lnk ();

    febc_state_t            state_r, state_nxt;
    logic [2:0]             ds_nv_r, ds_nv_nxt;
    logic [2:0]             drive_sel_nxt;
    logic [31:0]            boot_r, boot_nxt;
    logic [31:0]            sh_r, sh_nxt;
    logic [2:0]             cnt_r, cnt_nxt;
    logic                   to_nv_r, to_nv_nxt;
    logic [3:0]             fall_cnt_r, fall_cnt_nxt;
    logic [BOOT_ADDR_W-1:0] boot_addr_nxt;
    logic                   boot_fetch_nxt;
    logic                   fetch_d_r;
    logic [7:0]             tx_byte_r, tx_byte_nxt;
    logic                   tx_on_r, tx_on_nxt;
    logic                   tx_sync_r, tx_sync_nxt;
    logic                   clear_cmd;
    logic                   prot_set, prog_set, erase_set;
    logic                   bad_mode, err_clr;
    logic [7:0]             ext_val;
    logic [3:0]             boot_dly;
    logic [BOOT_ADDR_W-1:0] boot_base;

    febc_link_front u_front (
        .sys_clk (sys_clk),
        .rst     (rst),
        .sck     (sck),
        .ce_n    (ce_n),
        .si      (si),
        .so_r    (so_r),
        .so_oe_r (so_oe_r),
        .lnk     (lnk.front)
    );

    assign lnk.tx_byte = tx_byte_r;
    assign lnk.tx_on   = tx_on_r;
    assign lnk.tx_sync = tx_sync_r;

    // read image of the extended status register
    always_comb
    begin
        ext_val                          = 8'h00;
        ext_val[EXT_WIP_BIT]             = busy;
        ext_val[EXT_PROT_BIT]            = prot_err_r;
        ext_val[EXT_PERR_BIT]            = prog_err_r;
        ext_val[EXT_EERR_BIT]            = erase_err_r;
        ext_val[EXT_RSVD_BIT]            = EXT_RSVD_VAL;
        ext_val[EXT_DS_MSB:EXT_DS_LSB]   = drive_sel_r;
    end

    // boot fields decoded from the stored word
    assign boot_dly  = boot_r[BOOT_DLY_MSB:BOOT_DLY_LSB];
    assign boot_base = BOOT_ADDR_W'(boot_r[BOOT_ADDR_MSB:BOOT_ADDR_LSB])
                       << BOOT_ALIGN_SH;

    // outcome classification into error set terms
    always_comb
    begin
        prot_set  = 1'b0;
        prog_set  = 1'b0;
        erase_set = 1'b0;
        bad_mode  = mode_chosen || (mode_lock_bits == 2'h0);
        if (op_done)
        begin
            unique case (op_kind)
                FEBC_OP_PROGRAM, FEBC_OP_INFO_PROG:
                begin
                    prog_set = op_fail | op_hit_protect;
                    prot_set = op_hit_protect;
                end
                FEBC_OP_MODE_PROG:
                begin
                    prog_set = op_fail | bad_mode;
                    prot_set = bad_mode;
                end
                FEBC_OP_UNLOCK:
                begin
                    prog_set = ~pwd_match;
                    prot_set = ~pwd_match;
                end
                FEBC_OP_NV_REG:
                begin
                    prog_set  = nv_prog_fail;
                    erase_set = nv_erase_fail;
                end
                FEBC_OP_FUNC_WR:
                    prog_set = op_fail;                   // otp clears are no fail
                FEBC_OP_ERASE:
                begin
                    erase_set = op_fail | op_hit_protect;
                    prot_set  = op_hit_protect;
                end
                FEBC_OP_CHIP_ERASE:
                    erase_set = op_fail;                  // protected skip is silent
            endcase
        end
    end

    // sticky flags; a set in the clearing cycle wins
    assign err_clr = clear_cmd | soft_rst;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            prot_err_r  <= 1'b0;
            prog_err_r  <= 1'b0;
            erase_err_r <= 1'b0;
        end
        else
        begin
            prot_err_r  <= (prot_err_r & ~err_clr) | prot_set;
            prog_err_r  <= (prog_err_r & ~err_clr) | prog_set;
            erase_err_r <= (erase_err_r & ~err_clr) | erase_set;
        end
    end

    // command sequencing, register writes and boot streaming
    always_comb
    begin
        state_nxt      = state_r;
        ds_nv_nxt      = ds_nv_r;
        drive_sel_nxt  = drive_sel_r;
        boot_nxt       = boot_r;
        sh_nxt         = sh_r;
        cnt_nxt        = cnt_r;
        to_nv_nxt      = to_nv_r;
        fall_cnt_nxt   = fall_cnt_r;
        boot_addr_nxt  = boot_addr_r;
        boot_fetch_nxt = 1'b0;
        tx_byte_nxt    = tx_byte_r;
        tx_on_nxt      = tx_on_r;
        tx_sync_nxt    = 1'b0;
        clear_cmd      = 1'b0;
        if (soft_rst)
            drive_sel_nxt = ds_nv_r;
        if (fetch_d_r)
            tx_byte_nxt = boot_data;
        if (lnk.frame_start)
        begin
            cnt_nxt      = 3'h0;
            fall_cnt_nxt = 4'h0;
            tx_on_nxt    = 1'b0;
            state_nxt    = ST_CMD;
            if (boot_r[BOOT_EN_BIT])
            begin
                state_nxt = ST_BOOT_WAIT;
                if (boot_dly == 4'h0)
                begin
                    state_nxt      = ST_BOOT_RUN;
                    boot_addr_nxt  = boot_base;
                    boot_fetch_nxt = 1'b1;
                    tx_on_nxt      = 1'b1;
                    tx_sync_nxt    = 1'b1;
                end
            end
        end
        else if (lnk.frame_end)
        begin
            // commits happen only on a complete frame
            if (state_r == ST_WR_EXT && cnt_r != 3'h0)
            begin
                drive_sel_nxt = sh_r[EXT_DS_MSB:EXT_DS_LSB]; // status bits dropped
                if (to_nv_r)
                    ds_nv_nxt = sh_r[EXT_DS_MSB:EXT_DS_LSB];
            end
            if (state_r == ST_WR_BOOT && cnt_r == BOOT_BYTES)
                boot_nxt = sh_r & BOOT_WR_MASK;
            state_nxt = ST_CMD;
            tx_on_nxt = 1'b0;
        end
        else
        begin
            unique case (state_r)
                ST_CMD:
                    if (lnk.rx_valid)
                    begin
                        state_nxt = ST_IGNORE;
                        unique case (lnk.rx_byte)
                            OPC_READ_EXT:
                            begin
                                state_nxt   = ST_RD_EXT;
                                tx_byte_nxt = ext_val;
                                tx_on_nxt   = 1'b1;
                            end
                            OPC_READ_BOOT:
                            begin
                                state_nxt   = ST_RD_BOOT;
                                tx_byte_nxt = boot_r[31:24];
                                sh_nxt      = {boot_r[23:0], 8'h00};
                                tx_on_nxt   = 1'b1;
                            end
                            OPC_SET_PARAMS_NV, OPC_SET_PARAMS_V:
                            begin
                                state_nxt = ST_WR_EXT;
                                to_nv_nxt = (lnk.rx_byte == OPC_SET_PARAMS_NV);
                            end
                            OPC_WRITE_BOOT:
                                state_nxt = ST_WR_BOOT;
                            OPC_CLEAR_ERR:
                                clear_cmd = 1'b1;
                            default:
                                state_nxt = ST_IGNORE;      // other codes run elsewhere
                        endcase
                    end
                ST_RD_EXT:
                    if (lnk.tx_take)
                        tx_byte_nxt = ext_val;              // live status repeated
                ST_RD_BOOT:
                    if (lnk.tx_take)
                    begin
                        tx_byte_nxt = sh_r[31:24];
                        sh_nxt      = {sh_r[23:0], 8'h00};
                    end
                ST_WR_EXT:
                    if (lnk.rx_valid && cnt_r == 3'h0)
                    begin
                        sh_nxt  = {24'h000000, lnk.rx_byte};
                        cnt_nxt = 3'h1;
                    end
                ST_WR_BOOT:
                    if (lnk.rx_valid && cnt_r != BOOT_BYTES)
                    begin
                        sh_nxt  = {sh_r[23:0], lnk.rx_byte};
                        cnt_nxt = cnt_r + 3'h1;
                    end
                ST_IGNORE:
                    state_nxt = ST_IGNORE;
                ST_BOOT_WAIT:
                    if (lnk.sck_fall)
                    begin
                        fall_cnt_nxt = fall_cnt_r + 4'h1;
                        if (fall_cnt_r + 4'h1 == boot_dly)
                        begin
                            state_nxt      = ST_BOOT_RUN;
                            boot_addr_nxt  = boot_base;
                            boot_fetch_nxt = 1'b1;
                            tx_on_nxt      = 1'b1;
                            tx_sync_nxt    = 1'b1;
                        end
                    end
                ST_BOOT_RUN:
                    if (lnk.tx_take)
                    begin
                        boot_addr_nxt  = boot_addr_r + BOOT_ADDR_W'(1);
                        boot_fetch_nxt = 1'b1;
                    end
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            state_r       <= ST_CMD;
            ds_nv_r       <= DS_RESET;
            drive_sel_r   <= DS_RESET;
            boot_r        <= BOOT_RESET;
            boot_enable_r <= 1'b0;
            sh_r          <= 32'h0000_0000;
            cnt_r         <= 3'h0;
            to_nv_r       <= 1'b0;
            fall_cnt_r    <= 4'h0;
            boot_addr_r   <= '0;
            boot_fetch_r  <= 1'b0;
            fetch_d_r     <= 1'b0;
            tx_byte_r     <= 8'h00;
            tx_on_r       <= 1'b0;
            tx_sync_r     <= 1'b0;
        end
        else
        begin
            state_r       <= state_nxt;
            ds_nv_r       <= ds_nv_nxt;
            drive_sel_r   <= drive_sel_nxt;
            boot_r        <= boot_nxt;
            boot_enable_r <= boot_nxt[BOOT_EN_BIT];
            sh_r          <= sh_nxt;
            cnt_r         <= cnt_nxt;
            to_nv_r       <= to_nv_nxt;
            fall_cnt_r    <= fall_cnt_nxt;
            boot_addr_r   <= boot_addr_nxt;
            boot_fetch_r  <= boot_fetch_nxt;
            fetch_d_r     <= boot_fetch_r;
            tx_byte_r     <= tx_byte_nxt;
            tx_on_r       <= tx_on_nxt;
            tx_sync_r     <= tx_sync_nxt;
        end
    end
endmodule : febc_core

// ---- core/febc_pkg.sv ----
// shared constants and types of the error status and boot config block
// assumes a single sys_clk domain; the serial pins are synchronised inside
package febc_pkg;
    // serial command codes
    localparam logic [7:0] OPC_SET_PARAMS_NV = 8'h85;
    localparam logic [7:0] OPC_SET_PARAMS_V  = 8'h83;
    localparam logic [7:0] OPC_READ_EXT      = 8'h81;
    localparam logic [7:0] OPC_CLEAR_ERR     = 8'h82;
    localparam logic [7:0] OPC_READ_BOOT     = 8'h14;
    localparam logic [7:0] OPC_WRITE_BOOT    = 8'h15;
    // extended read status layout
    localparam int EXT_WIP_BIT  = 0;
    localparam int EXT_PROT_BIT = 1;
    localparam int EXT_PERR_BIT = 2;
    localparam int EXT_EERR_BIT = 3;
    localparam int EXT_RSVD_BIT = 4;
    localparam int EXT_DS_LSB   = 5;
    localparam int EXT_DS_MSB   = 7;
    localparam logic       EXT_RSVD_VAL  = 1'b1;
    localparam logic [2:0] DS_RESET      = 3'h7;
    localparam logic [2:0] DS_RSVD_LOW   = 3'h0;
    localparam logic [2:0] DS_RSVD_HIGH  = 3'h4;
    // boot configuration layout
    localparam int BOOT_EN_BIT     = 0;
    localparam int BOOT_DLY_LSB    = 1;
    localparam int BOOT_DLY_MSB    = 4;
    localparam int BOOT_ADDR_LSB   = 5;
    localparam int BOOT_ADDR_MSB   = 23;
    localparam int BOOT_ALIGN_SH   = 9;
    localparam int BOOT_ADDR_W     = 28;
    localparam logic [31:0] BOOT_RESET   = 32'h0000_0000;
    localparam logic [31:0] BOOT_WR_MASK = 32'h00ff_ffff;
    localparam logic [2:0]  BOOT_BYTES   = 3'h4;
    // outcome classes reported by the command engine
    typedef enum logic [2:0] {
        FEBC_OP_PROGRAM,
        FEBC_OP_INFO_PROG,
        FEBC_OP_MODE_PROG,
        FEBC_OP_UNLOCK,
        FEBC_OP_NV_REG,
        FEBC_OP_FUNC_WR,
        FEBC_OP_ERASE,
        FEBC_OP_CHIP_ERASE
    } febc_op_t;
endpackage : febc_pkg

// ---- core/febc_link_if.sv ----
// signals between the serial front end and the register core
// assumes both ends run on sys_clk
`timescale 1ns/1ps
interface febc_link_if;
    logic       frame_start;
    logic       frame_end;
    logic       sck_fall;
    logic       rx_valid;
    logic [7:0] rx_byte;
    logic [7:0] tx_byte;
    logic       tx_on;
    logic       tx_sync;
    logic       tx_take;
    modport front (output frame_start, frame_end, sck_fall, rx_valid, rx_byte, tx_take,
                   input tx_byte, tx_on, tx_sync);
    modport core  (input frame_start, frame_end, sck_fall, rx_valid, rx_byte, tx_take,
                   output tx_byte, tx_on, tx_sync);
endinterface : febc_link_if

// ---- core/febc_link_front.sv ----
// serial front end: pin synchronisers, edge finding, byte shifters
// assumes mode 0 framing, serial clock far slower than sys_clk
`timescale 1ns/1ps
module febc_link_front (
    input  wire logic   sys_clk,
    input  wire logic   rst,
    input  wire logic   sck,
    input  wire logic   ce_n,
    input  wire logic   si,
    output logic        so_r,
    output logic        so_oe_r,
    febc_link_if.front  lnk
);
    logic [2:0] meta_r;
    logic [2:0] sync_r;
    logic [1:0] dly_r;
    logic [7:0] rx_sh_r, rx_sh_nxt;
    logic [2:0] rx_cnt_r, rx_cnt_nxt;
    logic [7:0] rx_byte_r, rx_byte_nxt;
    logic       rx_valid_r, rx_valid_nxt;
    logic [6:0] tx_sh_r, tx_sh_nxt;
    logic [2:0] tx_cnt_r, tx_cnt_nxt;
    logic       take_r, take_nxt;
    logic       so_nxt, oe_nxt;
    logic       fs_r, fe_r, fall_r;
    logic       rise, fall, active;

    // two stages on sck, ce_n, si; only stage two feeds logic
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            meta_r <= 3'h6;
            sync_r <= 3'h6;
            dly_r  <= 2'h3; // idle ce_n high, no false frame end
        end
        else
        begin
            meta_r <= {sck, ce_n, si};
            sync_r <= meta_r;
            dly_r  <= sync_r[2:1];
        end
    end

    assign active = ~sync_r[1];
    assign rise   = sync_r[2] & ~dly_r[1] & active;
    assign fall   = ~sync_r[2] & dly_r[1] & active;

    // receive on rising, transmit on falling sck
    always_comb
    begin
        rx_sh_nxt    = rx_sh_r;
        rx_cnt_nxt   = rx_cnt_r;
        rx_byte_nxt  = rx_byte_r;
        rx_valid_nxt = 1'b0;
        tx_sh_nxt    = tx_sh_r;
        tx_cnt_nxt   = tx_cnt_r;
        take_nxt     = 1'b0;
        so_nxt       = so_r;
        oe_nxt       = so_oe_r & active;
        if (!active)
        begin
            rx_cnt_nxt = 3'h0;
            tx_cnt_nxt = 3'h0;
        end
        if (rise)
        begin
            rx_sh_nxt  = {rx_sh_r[6:0], sync_r[0]};
            rx_cnt_nxt = rx_cnt_r + 3'h1;
            if (rx_cnt_r == 3'h7)
            begin
                rx_valid_nxt = 1'b1;
                rx_byte_nxt  = {rx_sh_r[6:0], sync_r[0]};
            end
        end
        if (lnk.tx_sync)
            tx_cnt_nxt = 3'h0;
        else if (fall && lnk.tx_on)
        begin
            tx_cnt_nxt = tx_cnt_r + 3'h1;
            oe_nxt     = 1'b1;
            if (tx_cnt_r == 3'h0)
            begin
                so_nxt    = lnk.tx_byte[7];
                tx_sh_nxt = lnk.tx_byte[6:0];
                take_nxt  = 1'b1;
            end
            else
            begin
                so_nxt    = tx_sh_r[6];
                tx_sh_nxt = {tx_sh_r[5:0], 1'b0};
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            rx_sh_r    <= 8'h00;
            rx_cnt_r   <= 3'h0;
            rx_byte_r  <= 8'h00;
            rx_valid_r <= 1'b0;
            tx_sh_r    <= 7'h00;
            tx_cnt_r   <= 3'h0;
            take_r     <= 1'b0;
            so_r       <= 1'b0;
            so_oe_r    <= 1'b0;
            fs_r       <= 1'b0;
            fe_r       <= 1'b0;
            fall_r     <= 1'b0;
        end
        else
        begin
            rx_sh_r    <= rx_sh_nxt;
            rx_cnt_r   <= rx_cnt_nxt;
            rx_byte_r  <= rx_byte_nxt;
            rx_valid_r <= rx_valid_nxt;
            tx_sh_r    <= tx_sh_nxt;
            tx_cnt_r   <= tx_cnt_nxt;
            take_r     <= take_nxt;
            so_r       <= so_nxt;
            so_oe_r    <= oe_nxt;
            fs_r       <= ~sync_r[1] & dly_r[0];
            fe_r       <= sync_r[1] & ~dly_r[0];
            fall_r     <= fall;
        end
    end

    assign lnk.frame_start = fs_r;
    assign lnk.frame_end   = fe_r;
    assign lnk.sck_fall    = fall_r;
    assign lnk.rx_valid    = rx_valid_r;
    assign lnk.rx_byte     = rx_byte_r;
    assign lnk.tx_take     = take_r;
endmodule : febc_link_front

// ---- testbench/febc_core_sva.sv ----
// checker on the engine outcome flags of febc_core
// assumes it is bound into febc_core and sees its ports only
`timescale 1ns/1ps
module febc_core_sva
    import febc_pkg::*;
(
    input wire logic               sys_clk,
    input wire logic               rst,
    input wire logic               ce_n,
    input wire logic               soft_rst,
    input wire logic               op_done,
    input wire febc_pkg::febc_op_t op_kind,
    input wire logic               op_fail,
    input wire logic               op_hit_protect,
    input wire logic               pwd_match,
    input wire logic               prot_err_r,
    input wire logic               prog_err_r,
    input wire logic               erase_err_r
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_erase_protect: assert property (op_done && op_kind == FEBC_OP_ERASE && op_hit_protect
        |=> prot_err_r && erase_err_r) else $error("protected erase not flagged");
    a_erase_fail: assert property (op_done && op_kind == FEBC_OP_ERASE && op_fail
        |=> erase_err_r) else $error("erase failure not flagged");
    a_prog_protect: assert property (op_done && op_kind == FEBC_OP_PROGRAM && op_hit_protect
        |=> prot_err_r && prog_err_r) else $error("protected program not flagged");
    a_func_fail: assert property (op_done && op_kind == FEBC_OP_FUNC_WR && op_fail
        |=> prog_err_r) else $error("function write failure not flagged");
    a_unlock_bad: assert property (op_done && op_kind == FEBC_OP_UNLOCK && !pwd_match
        |=> prot_err_r && prog_err_r) else $error("bad password not flagged");
    a_chip_quiet: assert property (op_done && op_kind == FEBC_OP_CHIP_ERASE && !op_fail
        && !prot_err_r && !erase_err_r |=> !prot_err_r && !erase_err_r)
        else $error("chip erase raised a flag");
    a_soft_clear: assert property (soft_rst && !op_done
        |=> !prot_err_r && !prog_err_r && !erase_err_r) else $error("soft reset kept flags");
    a_flags_sticky: assert property (ce_n [*8] ##0 !soft_rst
        |=> !$fell(prot_err_r) && !$fell(prog_err_r) && !$fell(erase_err_r))
        else $error("flag dropped without clear");
endmodule : febc_core_sva
bind febc_core febc_core_sva febc_core_sva_i (.*);

// ---- testbench/febc_host_model.sv ----
// serial host: frames a command of n bytes and shifts in the reply
// assumes one caller at a time, mode 0 with sck idle low
`timescale 1ns/1ps
module febc_host_model (
    input  wire logic sys_clk,
    input  wire logic so,
    output logic      sck  = 1'b0,
    output logic      ce_n = 1'b1,
    output logic      si   = 1'b0
);
    // one frame, msb first, 125 ns bit period
    task automatic frame(input logic [63:0] tx, input int n, output logic [63:0] rx);
        rx = '0;
        @(negedge sys_clk);
        ce_n = 1'b0;
        repeat (4) @(negedge sys_clk);
        for (int b = 0; b < 8 * n; b++)
        begin
            si = tx[63 - b];
            repeat (12) @(negedge sys_clk);
            sck = 1'b1;
            rx  = {rx[62:0], so};
            repeat (13) @(negedge sys_clk);
            sck = 1'b0;
        end
        repeat (4) @(negedge sys_clk);
        ce_n = 1'b1;
        si   = ~si; // no stale level outside a frame
        repeat (8) @(negedge sys_clk);
    endtask : frame
endmodule : febc_host_model

// ---- testbench/febc_core_test.sv ----
// self-checking bench for febc_core
// assumes the host model on the pins and a boot memory model here
`timescale 1ns/1ps
module febc_core_test;
    import febc_pkg::*;
    logic        sys_clk = 1'b0, rst = 1'b1, busy = 1'b0, soft_rst = 1'b0, op_done = 1'b0;
    febc_op_t    op_kind = FEBC_OP_PROGRAM;
    logic [7:0]  op_bits = 8'h1c;
    logic [7:0]  boot_data = 8'h00;
    logic        sck, ce_n, si, so_r, so_oe_r, boot_fetch_r, boot_enable_r;
    logic        prot_err_r, prog_err_r, erase_err_r;
    logic [27:0] boot_addr_r;
    logic [2:0]  drive_sel_r;
    logic [63:0] rx;
    int          n_fail = 0, cmp_count = 0;
    initial forever #2.5 sys_clk = ~sys_clk;
    // boot memory: byte depends on address
    always @(negedge sys_clk) boot_data <= boot_addr_r[7:0] ^ 8'h5a;
    febc_core febc_core_i (.*, .op_fail(op_bits[7]), .op_hit_protect(op_bits[6]),
        .mode_chosen(op_bits[5]), .mode_lock_bits(op_bits[4:3]), .pwd_match(op_bits[2]),
        .nv_erase_fail(op_bits[1]), .nv_prog_fail(op_bits[0]));
    febc_host_model febc_host_model_i (.sys_clk(sys_clk), .so(so_oe_r ? so_r : 1'b1),
        .sck(sck), .ce_n(ce_n), .si(si));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic stop_test;
        $display("fails %0d compares %0d", n_fail, cmp_count);
        if (n_fail == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : stop_test
    task automatic cmd(input logic [63:0] tx, input int n);
        febc_host_model_i.frame(tx, n, rx);
    endtask : cmd
    task automatic t_reset;
        rst = 1'b1;
        repeat (10) @(negedge sys_clk);
        rst = 1'b0;
        repeat (4) @(negedge sys_clk);
        chk({boot_enable_r, drive_sel_r, prot_err_r, prog_err_r, erase_err_r}, 7'h38);
        cmd({8'h81, 56'h0}, 2);
        chk(rx[7:0], 8'hf0);
        cmd({8'h14, 56'h0}, 5);
        chk(rx[31:0], 32'h0);
    endtask : t_reset
    task automatic t_busy;
        busy = 1'b1;
        cmd({8'h81, 56'h0}, 2);
        chk(rx[7:0], 8'hf1);
        busy = 1'b0;
        cmd({8'h9f, 56'h0}, 2);
        chk(rx[7:0], 8'hff);
    endtask : t_busy
    // outcome pulse, flag check, ext byte, then clear command
    task automatic t_op(input febc_op_t k, input logic [7:0] b, input logic [2:0] e);
        op_kind = k;
        op_bits = b;
        op_done = 1'b1;
        @(negedge sys_clk);
        op_done = 1'b0;
        @(negedge sys_clk);
        chk({prot_err_r, prog_err_r, erase_err_r}, e);
        cmd({8'h81, 56'h0}, 2);
        chk(rx[7:0], {4'hf, e[0], e[1], e[2], 1'b0});
        cmd({8'h82, 56'h0}, 1);
        chk({prot_err_r, prog_err_r, erase_err_r}, 3'h0);
    endtask : t_op
    task automatic t_sticky;
        op_kind = FEBC_OP_ERASE;
        op_bits = 8'h9c;
        op_done = 1'b1;
        @(negedge sys_clk);
        op_done = 1'b0;
        cmd({8'h85, 8'h3f, 48'h0}, 2);
        cmd({8'h83, 8'hc0, 48'h0}, 2);
        chk({drive_sel_r, erase_err_r}, 4'hd);
        soft_rst = 1'b1;
        @(negedge sys_clk);
        soft_rst = 1'b0;
        @(negedge sys_clk);
        chk({drive_sel_r, erase_err_r}, 4'h2);
    endtask : t_sticky
    task automatic t_boot;
        cmd({8'h15, 32'hff00_0202, 24'h0}, 5);
        cmd({8'h14, 56'h0}, 5);
        chk(rx[31:0], 32'h0000_0202);
        cmd({8'h15, 32'h0000_0001, 24'h0}, 5);
        cmd({8'h81, 56'h0}, 2);
        chk(rx[14:7], 8'h5a);
        t_reset();
        cmd({8'h15, 32'h0000_0203, 24'h0}, 5);
        chk(boot_enable_r, 1'b1);
        cmd({8'h81, 56'h0}, 3);
        chk(rx[21:6], 16'h5a5b);
        chk({boot_fetch_r, boot_addr_r}, 29'h000_2003);
    endtask : t_boot
    initial
    begin
        #200000;
        n_fail++;
        stop_test();
    end
    initial
    begin
        t_reset();
        t_busy();
        t_op(FEBC_OP_PROGRAM, 8'h5c, 3'h6);
        t_op(FEBC_OP_PROGRAM, 8'h9c, 3'h2);
        t_op(FEBC_OP_INFO_PROG, 8'h5c, 3'h6);
        t_op(FEBC_OP_MODE_PROG, 8'h04, 3'h6);
        t_op(FEBC_OP_MODE_PROG, 8'h34, 3'h6);
        t_op(FEBC_OP_MODE_PROG, 8'h14, 3'h0);
        t_op(FEBC_OP_UNLOCK, 8'h18, 3'h6);
        t_op(FEBC_OP_UNLOCK, 8'h1c, 3'h0);
        t_op(FEBC_OP_NV_REG, 8'h1e, 3'h1);
        t_op(FEBC_OP_NV_REG, 8'h1d, 3'h2);
        t_op(FEBC_OP_FUNC_WR, 8'h9c, 3'h2);
        t_op(FEBC_OP_ERASE, 8'h5c, 3'h5);
        t_op(FEBC_OP_ERASE, 8'h9c, 3'h1);
        t_op(FEBC_OP_CHIP_ERASE, 8'h5c, 3'h0);
        t_op(FEBC_OP_CHIP_ERASE, 8'h9c, 3'h1);
        t_sticky();
        t_boot();
        t_reset();
        stop_test();
    end
endmodule : febc_core_test
